// ### rtl/lom_mix_regs.sv
// line-output mixing register bank with apb access
`timescale 1ns/1ps
`default_nettype none
module lom_mix_regs (
   // clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      resetn,
   input  wire logic                      ce,
   // apb
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [lom_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   // analog status
   input  wire logic                      left_line_output_powered,
   // analog mixer controls
   output logic      [5:0]                left_route,
   output logic      [41:0]               left_vol,
   output logic      [2:0]                right_route,
   output logic      [20:0]               right_vol,
   output logic      [3:0]                left_level,
   output logic                           left_unmute,
   output logic                           left_gain_pending
);

   lom_reg_if rb ();

   logic [7:0] mix_r [lom_pkg::NUM_MIX];
   logic [3:0] level_r;
   logic       unmute_r;
   logic       pwr_r;
   logic       wr_left;
   logic       wr_level;
   logic [7:0] level_rd;

   // =====================================================================
   // bus front end
   lom_apb_port u_port (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .ce      (ce),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .rb      (rb.port)
   );

   // =====================================================================
   // decode of the bank window
   assign rb.hit = (rb.idx >= lom_pkg::IDX_L2L_TO_LEFT)
                 && (rb.idx <= lom_pkg::IDX_LCONV_TO_RIGHT);
   assign wr_level = rb.wr_stb && (rb.idx == lom_pkg::IDX_LEFT_LEVEL);
   assign wr_left  = rb.wr_stb && (rb.idx >= lom_pkg::IDX_L2L_TO_LEFT)
                   && (rb.idx <= lom_pkg::IDX_LEFT_LEVEL);

   // =====================================================================
   // source registers, one per mixing path
   genvar g;
   generate
      for (g = 0; g < lom_pkg::NUM_MIX; g++) begin : g_mix
         // left sources sit below the level register, right ones above
         localparam logic [6:0] IDX = (g < lom_pkg::NUM_LEFT_SRC)
            ? 7'(int'(lom_pkg::IDX_L2L_TO_LEFT) + g)
            : 7'(int'(lom_pkg::IDX_L2L_TO_LEFT) + g + 1);

         // write the route bit and volume code
         always_ff @(posedge sys_clk) begin
            if (!resetn) begin
               mix_r[g] <= lom_pkg::MIX_RST;
            end else if (ce && rb.wr_stb && rb.idx == IDX) begin
               mix_r[g] <= rb.wdata;
            end
         end

         if (g < lom_pkg::NUM_LEFT_SRC) begin : g_left
            assign left_route[g] = mix_r[g][lom_pkg::ROUTE_BIT];
            assign left_vol[g*7 +: 7] = mix_r[g][lom_pkg::VOL_MSB:0];
         end else begin : g_right
            assign right_route[g-lom_pkg::NUM_LEFT_SRC] =
               mix_r[g][lom_pkg::ROUTE_BIT];
            assign right_vol[(g-lom_pkg::NUM_LEFT_SRC)*7 +: 7] =
               mix_r[g][lom_pkg::VOL_MSB:0];
         end
      end
   endgenerate

   // =====================================================================
   // left output level and mute
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         level_r  <= lom_pkg::LVL_RST;
         unmute_r <= lom_pkg::UNMUTE_RST;
      end else if (ce && wr_level) begin
         level_r  <= rb.wdata[lom_pkg::LVL_MSB:lom_pkg::LVL_LSB];
         unmute_r <= rb.wdata[lom_pkg::MUTE_BIT];
      end
   end

   assign left_level  = level_r;
   assign left_unmute = unmute_r;

   // power status sampled from the analog driver
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pwr_r <= lom_pkg::PWR_RST;
      end else if (ce) begin
         pwr_r <= left_line_output_powered;
      end
   end

   // =====================================================================
   // gain pending timer for the left path
   lom_settle u_settle (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .ce      (ce),
      .start   (wr_left),
      .busy    (left_gain_pending)
   );

   // =====================================================================
   // read mux; reserved level bit reads zero
   always_comb begin
      level_rd = 8'h00;
      level_rd[lom_pkg::LVL_MSB:lom_pkg::LVL_LSB] = level_r;
      level_rd[lom_pkg::MUTE_BIT] = unmute_r;
      level_rd[lom_pkg::RSVD_BIT] = 1'b0;
      level_rd[lom_pkg::PEND_BIT] = left_gain_pending;
      level_rd[lom_pkg::PWR_BIT]  = pwr_r;
   end

   always_comb begin
      rb.rdata = 8'h00;
      if (rb.idx == lom_pkg::IDX_LEFT_LEVEL) begin
         rb.rdata = level_rd;
      end else if (rb.idx >= lom_pkg::IDX_L2L_TO_LEFT && rb.idx < lom_pkg::IDX_LEFT_LEVEL) begin
         rb.rdata = mix_r[4'(rb.idx - lom_pkg::IDX_L2L_TO_LEFT)];
      end else if (rb.idx > lom_pkg::IDX_LEFT_LEVEL
                   && rb.idx <= lom_pkg::IDX_LCONV_TO_RIGHT) begin
         rb.rdata = mix_r[4'(rb.idx - lom_pkg::IDX_L2L_TO_LEFT - 7'h01)];
      end
   end

   // =====================================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   logic [11:0] pend_cnt_r;
   logic        setup_level_rd;

   // cycles the pending flag has stood since the last left write
   always_ff @(posedge sys_clk) begin
      if (!resetn || wr_left || !left_gain_pending) begin
         pend_cnt_r <= 12'h000;
      end else if (ce) begin
         pend_cnt_r <= pend_cnt_r + 12'h001;
      end
   end

   assign setup_level_rd = ce && psel && !penable && !pwrite
                        && paddr == {3'h0, lom_pkg::IDX_LEFT_LEVEL, 2'h0};

   property p_unmapped;
      ce && psel && !penable && paddr == {3'h0, 7'h4F, 2'h0} |=> pready && pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped index not refused");

   property p_left_route;
      rb.wr_stb && ce && rb.idx == lom_pkg::IDX_L2L_TO_LEFT
         |=> left_route[0] == $past(pwdata[7]);
   endproperty
   a_left_route: assert property (p_left_route) else $error("left route bit wrong");

   property p_left_vol;
      rb.wr_stb && ce && rb.idx == lom_pkg::IDX_LGAIN_TO_LEFT
         |=> left_vol[13:7] == $past(pwdata[6:0]);
   endproperty
   a_left_vol: assert property (p_left_vol) else $error("left volume code wrong");

   property p_right_path;
      rb.wr_stb && ce && rb.idx == lom_pkg::IDX_LCONV_TO_RIGHT
         |=> right_route[2] == $past(pwdata[7]) && right_vol[20:14] == $past(pwdata[6:0]);
   endproperty
   a_right_path: assert property (p_right_path) else $error("right path wrong");

   property p_level;
      wr_level && ce |=> left_level == $past(pwdata[7:4]);
   endproperty
   a_level: assert property (p_level) else $error("level field wrong");

   property p_mute;
      wr_level && ce |=> left_unmute == $past(pwdata[3]);
   endproperty
   a_mute: assert property (p_mute) else $error("mute bit wrong");

   property p_rsvd_zero;
      setup_level_rd |=> prdata[2] == 1'b0 && prdata[31:8] == 24'h00_0000;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit not zero");

   property p_pend_read;
      setup_level_rd |=> prdata[1] == $past(left_gain_pending);
   endproperty
   a_pend_read: assert property (p_pend_read) else $error("pending flag misread");

   property p_pwr_read;
      setup_level_rd |=> prdata[0] == $past(pwr_r);
   endproperty
   a_pwr_read: assert property (p_pwr_read) else $error("power status misread");

   property p_pend_set;
      wr_left && ce |=> left_gain_pending [*2];
   endproperty
   a_pend_set: assert property (p_pend_set) else $error("pending not set on write");

   property p_pend_bound;
      pend_cnt_r <= 12'(lom_pkg::SETTLE_CYC);
   endproperty
   a_pend_bound: assert property (p_pend_bound) else $error("pending never clears");

   c_write: cover property (rb.wr_stb && ce);
   c_level_read: cover property (setup_level_rd ##1 pready);
   c_settled: cover property ($fell(left_gain_pending));
   c_refused: cover property (pready && pslverr);
   c_frozen: cover property (!ce && left_gain_pending);

   // =====================================================================
   // bus answer shape: one-cycle pready, refused slots answer empty

   // pready is a single-cycle pulse per access
   property p_pready_pulse;
      ce && pready |=> !pready;
   endproperty
   a_pready_pulse: assert property (p_pready_pulse) else $error("pready too long");

   // a setup outside the bank window is refused with zero data
   property p_err_idle;
      ce && psel && !penable && !rb.hit |=> pslverr && prdata == 32'h0000_0000;
   endproperty
   a_err_idle: assert property (p_err_idle) else $error("outside index not refused");

   // a refused write leaves every mixer control alone
   property p_err_no_write;
      ce && psel && penable && pready && pslverr
         |=> $stable(left_route) && $stable(left_vol) && $stable(right_route)
             && $stable(right_vol) && $stable(left_level) && $stable(left_unmute);
   endproperty
   a_err_no_write: assert property (p_err_no_write) else $error("refused write landed");

   // only the low byte of a word carries register data
   property p_upper_zero;
      pready |-> prdata[31:8] == 24'h00_0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");

   // =====================================================================
   // inner ends of the source bank, next to the level register

   // last left source register drives the top slice
   property p_left_last;
      rb.wr_stb && rb.idx == lom_pkg::IDX_RCONV_TO_LEFT
         |=> left_route[5] == $past(pwdata[7]) && left_vol[41:35] == $past(pwdata[6:0]);
   endproperty
   a_left_last: assert property (p_left_last) else $error("last left source wrong");

   // first right source register drives the bottom slice
   property p_right_first;
      rb.wr_stb && rb.idx == lom_pkg::IDX_L2_TO_RIGHT
         |=> right_route[0] == $past(pwdata[7]) && right_vol[6:0] == $past(pwdata[6:0]);
   endproperty
   a_right_first: assert property (p_right_first) else $error("first right source wrong");

   // =====================================================================
   // pending flag and clock enable

   // right path writes never raise the left pending flag
   property p_right_no_pend;
      rb.wr_stb && rb.idx > lom_pkg::IDX_LEFT_LEVEL && !left_gain_pending
         |=> !left_gain_pending;
   endproperty
   a_right_no_pend: assert property (p_right_no_pend) else $error("right write set pending");

   // flag drops right after the full settle time
   property p_pend_clear;
      ce && !wr_left && pend_cnt_r == 12'(lom_pkg::SETTLE_CYC - 1) |=> !left_gain_pending;
   endproperty
   a_pend_clear: assert property (p_pend_clear) else $error("pending held too long");

   // low clock enable freezes controls, flag and answer
   property p_freeze;
      !ce |=> $stable(left_level) && $stable(left_unmute) && $stable(left_gain_pending)
              && $stable(pready) && $stable(left_route);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with enable low");

endmodule
`default_nettype wire

// ### rtl/lom_pkg.sv
// constants for the line-output mixing register bank
package lom_pkg;

   // =====================================================================
   // register indices (byte address is four times the index)
   localparam logic [6:0] IDX_L2L_TO_LEFT   = 7'h50;  // left2 to left output
   localparam logic [6:0] IDX_LGAIN_TO_LEFT = 7'h51;  // left gain stage to left output
   localparam logic [6:0] IDX_LCONV_TO_LEFT = 7'h52;  // left converter to left output
   localparam logic [6:0] IDX_R2_TO_LEFT    = 7'h53;  // right2 to left output
   localparam logic [6:0] IDX_RGAIN_TO_LEFT = 7'h54;  // right gain stage to left output
   localparam logic [6:0] IDX_RCONV_TO_LEFT = 7'h55;  // right converter to left output
   localparam logic [6:0] IDX_LEFT_LEVEL    = 7'h56;  // left output level control
   localparam logic [6:0] IDX_L2_TO_RIGHT   = 7'h57;  // left2 to right output
   localparam logic [6:0] IDX_LGAIN_TO_RIGHT = 7'h58; // left gain stage to right output
   localparam logic [6:0] IDX_LCONV_TO_RIGHT = 7'h59; // left converter to right output

   // =====================================================================
   // bank geometry
   localparam int NUM_MIX      = 9;  // source registers in the bank
   localparam int NUM_LEFT_SRC = 6;  // first six feed the left output
   localparam int NUM_RIGHT_SRC = 3;
   localparam int VOL_W        = 7;
   localparam int ADDR_W       = 12;

   // =====================================================================
   // field positions
   localparam int ROUTE_BIT = 7;
   localparam int VOL_MSB   = 6;
   localparam int LVL_MSB   = 7;
   localparam int LVL_LSB   = 4;
   localparam int MUTE_BIT  = 3;
   localparam int RSVD_BIT  = 2;
   localparam int PEND_BIT  = 1;
   localparam int PWR_BIT   = 0;

   // =====================================================================
   // reset values
   localparam logic [7:0] MIX_RST   = 8'h00;
   localparam logic [3:0] LVL_RST   = 4'h0;
   localparam logic       UNMUTE_RST = 1'b0;
   localparam logic       PEND_RST  = 1'b1;
   localparam logic       PWR_RST   = 1'b0;

   // =====================================================================
   // timing: gain settle time after a left path change
   localparam int CLK_PERIOD_NS  = 10;
   localparam int SETTLE_TIME_NS = 10000;
   localparam int SETTLE_CYC     = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_W       = 10;

endpackage

// ### rtl/lom_reg_if.sv
// internal register access carrier between bus port and register bank
`timescale 1ns/1ps
`default_nettype none
interface lom_reg_if;
   logic       wr_stb;  // one-cycle write commit
   logic [6:0] idx;     // register index
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       hit;     // index belongs to the bank

   modport port (output wr_stb, idx, wdata, input rdata, hit);
   modport bank (input wr_stb, idx, wdata, output rdata, hit);
endinterface
`default_nettype wire

// ### rtl/lom_apb_port.sv
// apb slave front end of the mixing register bank
`timescale 1ns/1ps
`default_nettype none
module lom_apb_port (
   // clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      resetn,
   input  wire logic                      ce,
   // apb
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [lom_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   // bank side
   lom_reg_if.port                        rb
);

   logic setup;
   logic ok;

   // =====================================================================
   // decode: aligned word inside the bank
   assign setup    = psel & ~penable;
   assign rb.idx   = paddr[8:2];
   assign rb.wdata = pwdata[7:0];
   assign ok       = rb.hit & (paddr[1:0] == 2'h0) & (paddr[11:9] == 3'h0);
   assign rb.wr_stb = ce & psel & penable & pready & pwrite & ~pslverr;

   // one wait-free access phase: answer registered at the setup edge
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (ce) begin
         pready <= setup;
         if (setup) begin
            pslverr <= ~ok;
            prdata  <= (ok && !pwrite) ? {24'h00_0000, rb.rdata} : 32'h0000_0000;
         end
      end
   end

endmodule
`default_nettype wire

// ### rtl/lom_settle.sv
// settle timer behind the left output gain pending flag
`timescale 1ns/1ps
`default_nettype none
module lom_settle (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic resetn,
   input  wire logic ce,
   // control
   input  wire logic start,
   output logic      busy
);

   logic [lom_pkg::SETTLE_W-1:0] count_r;

   // =====================================================================
   // reload on each change, count down to applied
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         count_r <= lom_pkg::SETTLE_W'(lom_pkg::SETTLE_CYC);
         busy    <= lom_pkg::PEND_RST;
      end else if (ce) begin
         if (start) begin                     // a new change wins over the clear
            count_r <= lom_pkg::SETTLE_W'(lom_pkg::SETTLE_CYC);
            busy    <= 1'b1;
         end else if (count_r > lom_pkg::SETTLE_W'(1)) begin
            count_r <= count_r - lom_pkg::SETTLE_W'(1);
         end else begin
            count_r <= '0;
            busy    <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the line-output mixing register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ======================================================================
   // signals and design hookup
   logic        sys_clk;
   logic        resetn;
   logic        ce;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        pwr_in;
   logic [5:0]  left_route;
   logic [41:0] left_vol;
   logic [2:0]  right_route;
   logic [20:0] right_vol;
   logic [3:0]  left_level;
   logic        left_unmute;
   logic        left_gain_pending;
   int          failures;
   int          checked;
   int          cycles;
   int          n;
   logic [7:0]  exp_mix [10];  // expected contents, offset from bank base
   logic [7:0]  d;
   logic [31:0] rd;
   logic        err;

   lom_mix_regs DUT (
      .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .left_line_output_powered(pwr_in), .left_route(left_route),
      .left_vol(left_vol), .right_route(right_route), .right_vol(right_vol),
      .left_level(left_level), .left_unmute(left_unmute),
      .left_gain_pending(left_gain_pending)
   );

   // ======================================================================
   // clock and hang guard
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 10000) begin
         failures++;
         summarize();
      end
   end

   // ======================================================================
   // reporting
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk_rd(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_port(input string what, input logic [63:0] exp, input logic [63:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // ======================================================================
   // apb master: setup, access until pready, then one idle cycle
   task automatic apb(input logic wr, input logic [6:0] idx, input logic [1:0] low,
                      input logic [31:0] wd, output logic [31:0] rdv, output logic errv);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {3'h0, idx, low};
      pwdata  <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) begin
         @(posedge sys_clk);
      end
      rdv = prdata;
      errv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   // upper data bits carry junk that the bank must ignore
   task automatic reg_wr(input int k, input logic [7:0] v);
      apb(1'b1, lom_pkg::IDX_L2L_TO_LEFT + 7'(k), 2'h0, {24'hA5C3E1, v}, rd, err);
      chk_port("write err", 64'h0, 64'(err));
   endtask

   task automatic reg_rchk(input int k, input logic [31:0] exp);
      apb(1'b0, lom_pkg::IDX_L2L_TO_LEFT + 7'(k), 2'h0, 32'h00000000, rd, err);
      chk_rd($sformatf("reg %0d", 80 + k), exp, rd);
      chk_port("read err", 64'h0, 64'(err));
   endtask

   // mixer control ports against the expected register image
   task automatic chk_ports();
      logic [41:0] lv;
      logic [5:0]  lr;
      logic [20:0] rv;
      logic [2:0]  rr;
      for (int i = 0; i < 6; i++) begin
         lr[i] = exp_mix[i][7];
         lv[7*i+:7] = exp_mix[i][6:0];
      end
      for (int j = 0; j < 3; j++) begin
         rr[j] = exp_mix[7+j][7];
         rv[7*j+:7] = exp_mix[7+j][6:0];
      end
      chk_port("left_route", 64'(lr), 64'(left_route));
      chk_port("left_vol", 64'(lv), 64'(left_vol));
      chk_port("right_route", 64'(rr), 64'(right_route));
      chk_port("right_vol", 64'(rv), 64'(right_vol));
      chk_port("left_level", 64'(exp_mix[6][7:4]), 64'(left_level));
      chk_port("left_unmute", 64'(exp_mix[6][3]), 64'(left_unmute));
   endtask

   task automatic do_reset();
      resetn <= 1'b0;
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      foreach (exp_mix[k]) exp_mix[k] = 8'h00;
   endtask

   // ======================================================================
   // test sequence
   initial begin
      resetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      pwr_in = 1'b0;
      failures = 0;
      checked = 0;
      cycles = 0;
      @(posedge sys_clk);
      do_reset();
      // reset image of the whole bank
      for (int k = 0; k < 10; k++) begin
         reg_rchk(k, (k == 6) ? 32'h00000002 : 32'h00000000);
      end
      chk_ports();
      chk_port("pending", 64'h1, 64'(left_gain_pending));
      // distinct patterns in every source register, route bits mixed
      for (int k = 0; k < 10; k++) begin
         if (k != 6) begin
            exp_mix[k] = 8'(k * 29 + 131);
            reg_wr(k, exp_mix[k]);
         end
      end
      chk_ports();
      for (int k = 0; k < 10; k++) begin
         if (k != 6) reg_rchk(k, {24'h000000, exp_mix[k]});
      end
      // unmapped neighbours and an unaligned address are refused
      apb(1'b1, 7'h4F, 2'h0, 32'h000000FF, rd, err);
      chk_port("err idx 79", 64'h1, 64'(err));
      apb(1'b1, 7'h5A, 2'h0, 32'h000000FF, rd, err);
      chk_port("err idx 90", 64'h1, 64'(err));
      apb(1'b0, 7'h5A, 2'h0, 32'h00000000, rd, err);
      chk_rd("rd idx 90", 32'h00000000, rd);
      apb(1'b1, lom_pkg::IDX_L2L_TO_LEFT, 2'h1, 32'h00000000, rd, err);
      chk_port("err unaligned", 64'h1, 64'(err));
      chk_ports();
      // level codes 0 to 9, unmute toggling, read-only bits written high
      pwr_in <= 1'b1;
      for (int l = 0; l < 10; l++) begin
         d = {4'(l), 1'(l), 3'b111};
         exp_mix[6] = {4'(l), 1'(l), 3'b000};
         reg_wr(6, d);
         chk_ports();
         reg_rchk(6, {24'h000000, exp_mix[6][7:3], 3'b011});
      end
      // pending restarts on a repeat write and clears after the settle time
      reg_wr(0, exp_mix[0]);
      repeat (500) @(posedge sys_clk);
      reg_wr(0, exp_mix[0]);
      n = 0;
      while (left_gain_pending !== 1'b0 && n < 1100) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk_port("settle window", 64'h1, 64'(n >= 990 && n <= 1005));
      reg_rchk(6, {24'h000000, exp_mix[6][7:3], 3'b001});
      // right-side write leaves pending clear; power status follows input
      reg_wr(8, 8'h7F);
      exp_mix[8] = 8'h7F;
      chk_port("pending right", 64'h0, 64'(left_gain_pending));
      pwr_in <= 1'b0;
      @(posedge sys_clk);
      reg_rchk(6, {24'h000000, exp_mix[6][7:3], 3'b000});
      chk_ports();
      // low clock enable freezes the settle timer
      reg_wr(0, exp_mix[0]);
      ce <= 1'b0;
      repeat (1100) @(posedge sys_clk);
      chk_port("pending frozen", 64'h1, 64'(left_gain_pending));
      ce <= 1'b1;
      @(posedge sys_clk);
      // second reset in mid-run restores the reset image
      do_reset();
      reg_rchk(8, 32'h00000000);
      reg_rchk(6, 32'h00000002);
      chk_ports();
      summarize();
   end
endmodule
`default_nettype wire
